// file: src/tat_pkg.sv
// package: register map, config layout and helpers for the thermal alarm block
`default_nettype none
package tat_pkg;
    // ****************************************
    // register map (word index, byte address = index * 4)
    // ****************************************
    localparam int ADDR_W = 5;
    localparam logic [1:0] IDX_TEMP = 2'h0;
    localparam logic [1:0] IDX_CFG = 2'h1;
    localparam logic [1:0] IDX_HYST = 2'h2;
    localparam logic [1:0] IDX_TRIP = 2'h3;
    localparam int IDX_LSB = 2;
    localparam int MAP_BIT = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] TEMP_RST = 16'h0000;
    localparam logic [15:0] HYST_RST = 16'h4B00;
    localparam logic [15:0] TRIP_RST = 16'h5000;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [3:0] ZERO_NIB = 4'h0;
    localparam logic [15:0] RD_PAD = 16'h0000;

    // ****************************************
    // data widths and fault counts
    // ****************************************
    localparam int RES_MIN = 9;
    localparam int TEMP_W = 16;
    localparam int ADC_W = 12;
    localparam logic [2:0] FAULT_N0 = 3'h1;
    localparam logic [2:0] FAULT_N1 = 3'h2;
    localparam logic [2:0] FAULT_N2 = 3'h4;
    localparam logic [2:0] FAULT_N3 = 3'h6;

    typedef struct packed {
        logic reserved;
        logic resolution_sel_hi;
        logic resolution_sel_lo;
        logic fault_count_sel_hi;
        logic fault_count_sel_lo;
        logic alert_polarity;
        logic mode_intr;
        logic shutdown_ctrl;
    } tat_cfg_s;

    typedef struct packed {
        logic done;
        logic [ADC_W-1:0] data;
    } tat_conv_s;

    typedef enum logic {TAT_ARM_UPPER, TAT_ARM_LOWER} tat_arm_e;

    // consecutive faults needed for a fault-count code
    function automatic logic [2:0] tat_fault_need(input logic [1:0] sel);
        unique case (sel)
            2'h0: tat_fault_need = FAULT_N0;
            2'h1: tat_fault_need = FAULT_N1;
            2'h2: tat_fault_need = FAULT_N2;
            2'h3: tat_fault_need = FAULT_N3;
        endcase
    endfunction

    // keeps the top (9 + res) bits of a temperature word
    function automatic logic [15:0] tat_res_mask(input logic [1:0] res);
        tat_res_mask = ~(16'hFFFF >> (RES_MIN + int'(res)));
    endfunction
endpackage
`default_nettype wire

// file: src/tat_thermal_alarm.sv
// thermal alarm: thresholds, fault queue, alert pin, shutdown, register slave
//
// Notes on behaviour
// - comparator mode checks each result against trip while alert is clear, hysteresis while set
// - comparator alert after N consecutive over-trip results
// - comparator alert released by first below-hysteresis result
// - shutdown leaves comparator alert unchanged
// - interrupt alert first set by N over-trip results
// - interrupt alert cleared by shutdown or register read
// - after clear, rearm on N below-hysteresis results
// - interrupt arming alternates trip then hysteresis
// - fault code 0..3 means 1,2,4,6 faults
// - fault code resets to zero, one fault
// - shutdown finishes current conversion then stands by
// - registers stay reachable; writing zero resumes
// - alert polarity resets to active low
// - resolution field selects 9 to 12 bits
// - leftmost temperature bit is the sign
// - thermostat runs from reset values alone
// - registers reachable at any time
// - mode bit zero comparator, one interrupt
// - compare only resolution-wide threshold bits
// - temperature left justified, unused low bits zero
`default_nettype none
module tat_thermal_alarm
    import tat_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // converter link
    input wire logic adc_clk,
    input wire logic adc_done,
    input wire logic [ADC_W-1:0] adc_data,
    output logic adc_run,
    // open-drain alert pin
    output logic alert_out_o,
    output logic alert_out_oe
);
    // ****************************************
    // converter link synchronisers
    // ****************************************
    logic clk_s1, clk_s2, clk_s3;
    tat_conv_s conv_s1, conv_s2;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            conv_s1 <= '0;
            conv_s2 <= '0;
        end else begin
            clk_s1 <= adc_clk;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            conv_s1 <= {adc_done, adc_data};
            conv_s2 <= conv_s1;
        end
    end

    // done and data are stable well before the slow link edge we sample on
    logic conv_evt;
    assign conv_evt = clk_s2 & ~clk_s3 & conv_s2.done;

    // ****************************************
    // state
    // ****************************************
    tat_cfg_s cfg, next_cfg;
    logic [15:0] temp, next_temp;
    logic [15:0] hyst, next_hyst;
    logic [15:0] trip, next_trip;
    logic [2:0] cnt, next_cnt;
    logic alert, next_alert;
    tat_arm_e arm, next_arm;
    logic pend, next_pend;
    logic next_run;
    logic next_wait;
    logic [31:0] next_rdata;

    logic [1:0] res;
    logic [15:0] mask, new_temp;
    logic above, below, cond, mapped, taken, rd_hit, wr_hit;
    logic [1:0] idx;
    logic [2:0] need;

    assign res = {cfg.resolution_sel_hi, cfg.resolution_sel_lo};
    assign mask = tat_res_mask(res);
    // sign stays in bit 15 of the left-justified word
    assign new_temp = {conv_s2.data, ZERO_NIB} & mask;
    assign above = $signed(new_temp) > $signed(trip & mask);
    assign below = $signed(new_temp) < $signed(hyst & mask);
    assign need = tat_fault_need({cfg.fault_count_sel_hi, cfg.fault_count_sel_lo});
    assign cond = (cfg.mode_intr && arm == TAT_ARM_LOWER) ? below : above;
    assign idx = avs_address[IDX_LSB+:2];
    assign mapped = ~avs_address[MAP_BIT];
    assign taken = (avs_read | avs_write) & ~avs_waitrequest;
    assign rd_hit = taken & avs_read & mapped;
    assign wr_hit = taken & avs_write & mapped;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        next_cfg = cfg;
        next_temp = temp;
        next_hyst = hyst;
        next_trip = trip;
        next_cnt = cnt;
        next_alert = alert;
        next_arm = arm;
        next_pend = pend;
        next_run = adc_run;
        next_wait = 1'b1;
        next_rdata = avs_readdata;

        // one wait cycle, then the answer stands for the taking edge
        if ((avs_read | avs_write) & avs_waitrequest) begin
            next_wait = 1'b0;
            next_rdata = '0;
            if (mapped) begin
                unique case (idx)
                    IDX_TEMP: next_rdata = {RD_PAD, temp};
                    IDX_CFG: next_rdata = {RD_PAD, 8'h00, cfg};
                    IDX_HYST: next_rdata = {RD_PAD, hyst};
                    IDX_TRIP: next_rdata = {RD_PAD, trip};
                endcase
            end
        end

        if (rd_hit && cfg.mode_intr) begin
            next_alert = 1'b0;
        end

        if (wr_hit) begin
            unique case (idx)
                IDX_TEMP: ;
                IDX_CFG: begin
                    if (avs_byteenable[0]) begin
                        next_cfg = tat_cfg_s'(avs_writedata[7:0]);
                        next_cfg.reserved = 1'b0;
                    end
                end
                IDX_HYST: begin
                    if (avs_byteenable[0]) next_hyst[7:0] = {avs_writedata[7:4], ZERO_NIB};
                    if (avs_byteenable[1]) next_hyst[15:8] = avs_writedata[15:8];
                end
                IDX_TRIP: begin
                    if (avs_byteenable[0]) next_trip[7:0] = {avs_writedata[7:4], ZERO_NIB};
                    if (avs_byteenable[1]) next_trip[15:8] = avs_writedata[15:8];
                end
            endcase
            // a mode change starts the fault queue afresh
            if (next_cfg.mode_intr != cfg.mode_intr) begin
                next_alert = 1'b0;
                next_cnt = '0;
                next_arm = TAT_ARM_UPPER;
            end
            if (next_cfg.shutdown_ctrl && !cfg.shutdown_ctrl) begin
                next_pend = adc_run;
                if (next_cfg.mode_intr) begin
                    next_alert = 1'b0;
                end
            end
            if (!next_cfg.shutdown_ctrl) begin
                next_pend = 1'b0;
                next_run = 1'b1;
            end
        end

        if (conv_evt && adc_run) begin
            // a result landing mid-read is kept out of the readable copy
            if (!(avs_read && idx == IDX_TEMP)) begin
                next_temp = new_temp;
            end
            if (pend && next_cfg.shutdown_ctrl) begin
                next_run = 1'b0;
                next_pend = 1'b0;
            end
            if (!alert) begin
                if (cond) begin
                    if (cnt + 3'h1 >= need) begin
                        next_alert = 1'b1;
                        next_cnt = '0;
                        if (cfg.mode_intr) begin
                            next_arm = (arm == TAT_ARM_UPPER) ? TAT_ARM_LOWER : TAT_ARM_UPPER;
                        end
                    end else begin
                        next_cnt = cnt + 3'h1;
                    end
                end else begin
                    next_cnt = '0;
                end
            end else if (!cfg.mode_intr && below) begin
                next_alert = 1'b0;
                next_cnt = '0;
            end
        end

        // a drop in resolution must not leave stale low bits behind
        next_temp = next_temp & tat_res_mask({next_cfg.resolution_sel_hi, next_cfg.resolution_sel_lo});
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg <= tat_cfg_s'(CFG_RST);
            temp <= TEMP_RST;
            hyst <= HYST_RST;
            trip <= TRIP_RST;
            cnt <= '0;
            alert <= 1'b0;
            arm <= TAT_ARM_UPPER;
            pend <= 1'b0;
            adc_run <= 1'b1;
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
            alert_out_o <= 1'b0;
            alert_out_oe <= 1'b0;
        end else begin
            cfg <= next_cfg;
            temp <= next_temp;
            hyst <= next_hyst;
            trip <= next_trip;
            cnt <= next_cnt;
            alert <= next_alert;
            arm <= next_arm;
            pend <= next_pend;
            adc_run <= next_run;
            avs_waitrequest <= next_wait;
            avs_readdata <= next_rdata;
            alert_out_o <= 1'b0;
            // open drain: active-high asserts by releasing the pin
            alert_out_oe <= next_cfg.alert_polarity ? ~next_alert : next_alert;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_pin_polarity: assert property (alert_out_oe == (cfg.alert_polarity ? ~alert : alert))
        else $error("alert pin does not follow alert and polarity");
    a_cmp_release: assert property (conv_evt && adc_run && alert && !cfg.mode_intr && below
        && !wr_hit |=> !alert)
        else $error("comparator alert not released below hysteresis");
    a_intr_read_clr: assert property (rd_hit && cfg.mode_intr && !conv_evt && !wr_hit |=> !alert)
        else $error("interrupt alert not cleared by read");
    a_alert_cause: assert property ($rose(alert) |-> $past(conv_evt) && $past(cnt) == need - 3'h1)
        else $error("alert rose without a full fault run");
    a_fault_reset: assert property (conv_evt && adc_run && !alert && !cond && !wr_hit |=> cnt == 3'h0)
        else $error("fault counter survived a broken run");
    a_arm_swap: assert property (cfg.mode_intr && $rose(alert) |-> arm != $past(arm))
        else $error("interrupt arming did not alternate");
    a_temp_format: assert property ((temp & ~mask) == 16'h0000 || $changed(res))
        else $error("temperature low bits not zero");
    a_sd_standby: assert property (conv_evt && adc_run && pend && !wr_hit |=> !adc_run)
        else $error("shutdown did not stand by after conversion");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_cmp_sd_hold: assert property (wr_hit && !cfg.mode_intr && !next_cfg.mode_intr
        && next_cfg.shutdown_ctrl && !conv_evt |=> alert == $past(alert))
        else $error("shutdown changed comparator alert");
    a_intr_hold: assert property (cfg.mode_intr && alert && !rd_hit && !wr_hit |=> alert)
        else $error("interrupt alert dropped without read or shutdown");
    a_cmp_hold: assert property (!cfg.mode_intr && alert && !wr_hit && !(conv_evt && adc_run && below)
        |=> alert)
        else $error("comparator alert dropped above hysteresis");

    // ****************************************
    // bus, shutdown and pin assertions
    // ****************************************
    a_run_resume: assert property (wr_hit && !next_cfg.shutdown_ctrl |=> adc_run)
        else $error("clearing shutdown did not resume conversions");
    a_standby_idle: assert property (!adc_run && !wr_hit |=> $stable(temp))
        else $error("temperature changed during standby");
    a_thresh_nibble: assert property (trip[3:0] == ZERO_NIB && hyst[3:0] == ZERO_NIB)
        else $error("threshold low bits not zero");
    a_rd_upper: assert property (avs_readdata[31:16] == RD_PAD)
        else $error("read data upper half not zero");
    a_pin_data: assert property (alert_out_o == 1'b0)
        else $error("open-drain pin driven high");

    // main scenarios
    c_intr_set: cover property (cfg.mode_intr && $rose(alert));
    c_intr_rearm: cover property (cfg.mode_intr && $rose(alert) && arm == TAT_ARM_UPPER);
    c_cmp_release: cover property (!cfg.mode_intr && $fell(alert));
    c_six_faults: cover property (need == FAULT_N3 && $rose(alert));
    c_standby: cover property ($fell(adc_run));
endmodule
`default_nettype wire

// file: testbench/tat_conv_model.sv
// converter model: link clock, done flag and result word
`default_nettype none
module tat_conv_model
    import tat_pkg::*;
(
    // converter link
    output logic adc_clk,
    output logic adc_done,
    output logic [ADC_W-1:0] adc_data,
    // standby request from the block
    input wire logic adc_run
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        adc_clk = 1'h0;
        adc_done = 1'h0;
        adc_data = 12'h000;
    end
    // link clock only moves inside a frame; released data goes inverted
    task automatic convert(input logic [ADC_W-1:0] v);
        if (adc_run !== 1'h1) begin
            return;
        end
        #3;
        adc_data = v;
        adc_done = 1'h1;
        #40 adc_clk = 1'h1;
        #40 adc_clk = 1'h0;
        #40 adc_done = 1'h0;
        adc_data = ~v;
    endtask
endmodule
`default_nettype wire

// file: testbench/tat_thermal_alarm_tb_top.sv
// testbench: alarm modes, fault queue, shutdown, data format
`default_nettype none
module tat_thermal_alarm_tb_top
    import tat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] HOT = 12'h510;
    localparam logic [11:0] COOL = 12'h100;
    logic clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic adc_clk, adc_done, adc_run, alert_out_o, alert_out_oe;
    logic [ADC_W-1:0] adc_data;
    logic [15:0] rv;
    logic [15:0] rst_tab[5] = '{16'h0000, 16'h0000, 16'h4B00, 16'h5000, 16'h0000};
    int need_tab[4] = '{1, 2, 4, 6};
    int err_count, checked;

    always #5 clk = ~clk;

    tat_thermal_alarm u_tat_thermal_alarm (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .adc_clk(adc_clk),
        .adc_done(adc_done), .adc_data(adc_data), .adc_run(adc_run),
        .alert_out_o(alert_out_o), .alert_out_oe(alert_out_oe));
    tat_conv_model u_tat_conv_model (
        .adc_clk(adc_clk), .adc_done(adc_done), .adc_data(adc_data), .adc_run(adc_run));

    // ****
    // checks and bus cycles
    // ****
    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [3:0] be,
                       output logic [15:0] q);
        int n;
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 20);
        if (avs_waitrequest !== 1'h0) begin
            err_count++;
            wrap_up();
        end
        q = avs_readdata[15:0];
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [1:0] i, output logic [15:0] q);
        bus(1'h0, {1'h0, i, 2'h0}, 16'h0000, 4'h0, q);
    endtask

    task automatic wr(input logic [1:0] i, input logic [15:0] d);
        bus(1'h1, {1'h0, i, 2'h0}, d, 4'h3, rv);
    endtask

    task automatic cv(input logic [11:0] v);
        u_tat_conv_model.convert(v);
        repeat (2) @(posedge clk);
    endtask

    // samples at the falling edge so the pin has settled
    task automatic oe(input logic e);
        @(negedge clk);
        chk("alert_out_oe", {15'h0000, e}, {15'h0000, alert_out_oe});
        chk("alert_out_o", 16'h0000, {15'h0000, alert_out_o});
        @(posedge clk);
    endtask

    function automatic logic [15:0] exp_t(input logic [11:0] v, input logic [1:0] r);
        return {v, 4'h0} & ~(16'hFFFF >> (9 + r));
    endfunction

    // ****
    // sequence
    // ****
    initial begin
        logic [1:0] r;
        logic [11:0] v;
        clk = 1'h0;
        sys_rst = 1'h1;
        avs_address = 5'h00;
        avs_read = 1'h0;
        avs_write = 1'h0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        err_count = 0;
        checked = 0;
        void'($urandom(38));
        repeat (5) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        oe(1'h0);
        for (int i = 0; i < 5; i++) begin
            bus(1'h0, 5'(i * 4), 16'h0000, 4'h0, rv);
            chk("reset value", rst_tab[i], rv);
        end
        cv(HOT);
        oe(1'h1);
        cv(12'h4B8);
        oe(1'h1);
        cv(COOL);
        oe(1'h0);
        for (int c = 0; c < 4; c++) begin
            wr(IDX_CFG, 16'(c << 3));
            repeat (need_tab[c] - 1) cv(HOT);
            cv(COOL);
            repeat (need_tab[c] - 1) cv(HOT);
            oe(1'h0);
            cv(HOT);
            oe(1'h1);
            cv(COOL);
            oe(1'h0);
        end
        wr(IDX_CFG, 16'h0000);
        cv(HOT);
        wr(IDX_CFG, 16'h0001);
        oe(1'h1);
        cv(12'h200);
        rd(IDX_TEMP, rv);
        chk("stored result", 16'h2000, rv);
        chk("adc_run", 16'h0000, {15'h0000, adc_run});
        wr(IDX_CFG, 16'h000A);
        chk("adc_run", 16'h0001, {15'h0000, adc_run});
        cv(HOT);
        oe(1'h0);
        cv(HOT);
        oe(1'h1);
        rd(IDX_TRIP, rv);
        oe(1'h0);
        cv(HOT);
        cv(HOT);
        oe(1'h0);
        cv(COOL);
        cv(COOL);
        oe(1'h1);
        rd(IDX_TEMP, rv);
        oe(1'h0);
        cv(HOT);
        cv(HOT);
        oe(1'h1);
        wr(IDX_CFG, 16'h000B);
        oe(1'h0);
        wr(IDX_CFG, 16'h0004);
        oe(1'h1);
        bus(1'h1, {1'h0, IDX_HYST, 2'h0}, 16'h12FF, 4'h1, rv);
        rd(IDX_HYST, rv);
        chk("hysteresis", 16'h4BF0, rv);
        wr(IDX_CFG, 16'h0000);
        wr(IDX_TRIP, 16'h5047);
        cv(12'h505);
        oe(1'h0);
        wr(IDX_CFG, 16'h0060);
        cv(12'h505);
        oe(1'h1);
        repeat (12) begin
            r = 2'($urandom_range(3));
            v = 12'($urandom);
            wr(IDX_CFG, {9'h000, r, 5'h00});
            cv(v);
            rd(IDX_TEMP, rv);
            chk("temperature", exp_t(v, r), rv);
            chk("sign", {15'h0000, v[11]}, {15'h0000, rv[15]});
        end
        wrap_up();
    end

    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
